// ---- common/sclk_pkg.sv ----
// Purpose: types of the system clock selector
// Assumes: nothing beyond the register header
// Notes:   all module state is held in the structs below
package sclk_pkg;

  // -------------------------------------------------------------------------
  // enumerations
  // -------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_WAKE = 4'b0001,
    SRC_PRESC = 4'b0010,
    SRC_PLL = 4'b0100,
    SRC_DIRECT = 4'b1000
  } sclk_src_e;

  typedef enum logic [1:0] {
    SW_RUN = 2'b01,
    SW_WAIT = 2'b10
  } sclk_sw_e;

  // -------------------------------------------------------------------------
  // state structs
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] src_sel;
    logic bypass;
    logic [1:0] band;
    logic ref_sel;
    logic [3:0] p_field;
    logic [7:0] n_field;
    logic [6:0] k2_field;
    logic [9:0] k1_field;
    logic flash_safe;
  } sclk_cfg_s;

  typedef struct packed {
    logic ref_d;
    logic [3:0] input_divider_field_cnt;
    logic [15:0] per_cnt;
    logic [15:0] pfd_per;
    logic [8:0] n_eff;
    logic [16:0] acc;
    logic vco;
    logic locked;
    logic enable;
  } sclk_pll_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sclk_cfg_s cfg;
    sclk_pll_s pll;
    sclk_sw_e sw;
    sclk_src_e act;
    logic sys_clk;
  } sclk_state_s;

  typedef struct packed {
    logic src_d;
    logic [10:0] cnt;
    logic [10:0] fac;
    logic out;
  } sclk_div_s;

endpackage

// ---- common/sclk_regs.svh ----
// Purpose: register offsets, field positions, reset values and codes of the system clock selector
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef SCLK_REGS_SVH
`define SCLK_REGS_SVH

// ---------------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------------
`define SCLK_ADDR_SYSCFG 12'h000
`define SCLK_ADDR_PLLCFG 12'h004
`define SCLK_ADDR_PRESC 12'h008
`define SCLK_ADDR_STMEM 12'h00c
`define SCLK_ADDR_STATUS 12'h010

// ---------------------------------------------------------------------------
// field positions (lsb)
// ---------------------------------------------------------------------------
`define SCLK_SYS_SRC_LSB 0
`define SCLK_PLL_BYP_BIT 0
`define SCLK_PLL_BAND_LSB 1
`define SCLK_PLL_REF_BIT 3
`define SCLK_PLL_P_LSB 4
`define SCLK_PLL_N_LSB 8
`define SCLK_PLL_K2_LSB 16
`define SCLK_PRESC_K1_LSB 0
`define SCLK_STMEM_SAFE_BIT 0
`define SCLK_STAT_SRC_LSB 0
`define SCLK_STAT_LOCK_BIT 4
`define SCLK_STAT_PLLEN_BIT 5
`define SCLK_STAT_SWBUSY_BIT 6
`define SCLK_STAT_LJ_LSB 16

// ---------------------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------------------
`define SCLK_RST_SRC 2'h0
`define SCLK_RST_BYP 1'h1
`define SCLK_RST_BAND 2'h0
`define SCLK_RST_REF 1'h0
`define SCLK_RST_P 4'h0
`define SCLK_RST_N 8'h00
`define SCLK_RST_K2 7'h00
`define SCLK_RST_K1 10'h000
`define SCLK_RST_SAFE 1'h0
`define SCLK_SEL_WAKE 2'h0
`define SCLK_SEL_OSC 2'h2
`define SCLK_SEL_DIRECT 2'h3
`define SCLK_LJ_VCO_MHZ 9'h1e0

`endif

// ---- tb/sclk_top_tb_top.sv ----
// Purpose: self-checking bench of the system clock selector
// Assumes: every clock source is a level stepped here on CLK; apb master written to the bus rules
// Notes:   expected periods are worked out from the source shapes and the divider fields
`timescale 1ns/1ps
`default_nettype none

`include "sclk_regs.svh"

module sclk_top_tb_top
  import sclk_pkg::*;
;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [3:0] src;
  logic SYS_CLK, PLL_ENABLE, PLL_LOCKED, FLASH_SAFE, rerr;
  logic [1:0] VCO_BAND;
  int hi_t[4], lo_t[4], cnt[4];
  int n_errors, tests_run, seed, per, hiw, i, k, sum;
  int kq[$];
  int pc[2], pe[2];

  sclk_top u_dut (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .WAKEUP_CLK(src[0]), .CRYSTAL_IN(src[1]), .INT_OSC(src[2]), .EXT_CLOCK_INPUT_ONE(src[3]),
    .SYS_CLK(SYS_CLK), .PLL_ENABLE(PLL_ENABLE), .PLL_LOCKED(PLL_LOCKED), .VCO_BAND(VCO_BAND),
    .FLASH_SAFE(FLASH_SAFE)
  );

  // ---------------------------------------------------------------------------
  // clock and source shapes
  // ---------------------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // each source stays high hi_t and low lo_t cycles
  always @(posedge CLK) begin
    for (int j = 0; j < 4; j++) begin
      cnt[j]++;
      if (cnt[j] >= (src[j] ? hi_t[j] : lo_t[j])) begin
        src[j] <= ~src[j];
        cnt[j] = 0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] near(input int s, input int e, input int t);
    return (s >= e - t && s <= e + t) ? e : s;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk_rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, {31'h0, err});
  endtask

  // period and high time of SYS_CLK, rising edge to rising edge
  task automatic meas(output int p, output int h);
    int n;
    logic prev, low;
    p = 0;
    h = 0;
    low = 1'b0;
    prev = 1'b1;
    for (n = 0; n < 12000; n++) begin
      @(posedge CLK);
      if (prev === 1'b0 && SYS_CLK === 1'b1) break;
      prev = SYS_CLK;
    end
    for (n = 0; n < 12000; n++) begin
      p++;
      if (SYS_CLK === 1'b1 && !low) h++;
      if (SYS_CLK !== 1'b1) low = 1'b1;
      @(posedge CLK);
      if (low && SYS_CLK === 1'b1) break;
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(40000 * 100);
    n_errors++;
    close_out;
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    seed = 32'h7744;
    n_errors = 0;
    tests_run = 0;
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    src = 4'h0;
    hi_t = '{3, 3, 4, 4};
    lo_t = '{2, 2, 4, 3};
    cnt = '{0, 0, 0, 0};
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    chk_rd(`SCLK_ADDR_SYSCFG, 32'h0, 1'b0);
    chk_rd(`SCLK_ADDR_PLLCFG, 32'h1, 1'b0);
    chk_rd(`SCLK_ADDR_PRESC, 32'h0, 1'b0);
    chk_rd(`SCLK_ADDR_STMEM, 32'h0, 1'b0);
    chk_rd(`SCLK_ADDR_STATUS, 32'h01e00001, 1'b0);
    chk_rd(12'h014, 32'h0, 1'b1);
    chk_rd(12'h002, 32'h0, 1'b1);
    meas(per, hiw);
    chk(per, 5);
    chk(hiw, 3);
    apb(1'b1, `SCLK_ADDR_STATUS, 32'hffffffff);
    chk_rd(`SCLK_ADDR_STATUS, 32'h01e00001, 1'b0);
    k = $random(seed);
    apb(1'b1, `SCLK_ADDR_STMEM, k);
    chk_rd(`SCLK_ADDR_STMEM, k & 1, 1'b0);
    chk({31'h0, FLASH_SAFE}, k & 1);
    for (k = 0; k < 3; k++) begin
      apb(1'b1, `SCLK_ADDR_PLLCFG, (k << 1) | 1);
      repeat (3) @(posedge CLK);
      chk({30'h0, VCO_BAND}, k);
    end
    apb(1'b1, `SCLK_ADDR_PLLCFG, 32'h1);
    apb(1'b1, `SCLK_ADDR_SYSCFG, 32'h2);
    kq = {0, 3, 1023};
    kq.insert(2, 1 + ($unsigned($random(seed)) % 9));
    foreach (kq[q]) begin
      apb(1'b1, `SCLK_ADDR_PRESC, kq[q]);
      meas(per, hiw);
      meas(per, hiw);
      chk(per, (kq[q] + 1) * 5);
      if (kq[q] == 0) chk(hiw, 3);
    end
    chk_rd(`SCLK_ADDR_STATUS, 32'h01e00002, 1'b0);
    apb(1'b1, `SCLK_ADDR_PLLCFG, 32'h9);
    apb(1'b1, `SCLK_ADDR_PRESC, 32'h1);
    meas(per, hiw);
    meas(per, hiw);
    chk(per, 16);
    hi_t[1] = 20;
    lo_t[1] = 20;
    pc = '{32'h00010300, 32'h00000710};
    pe = '{20, 10};
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `SCLK_ADDR_PLLCFG, 32'h1);
      repeat (4) @(posedge CLK);
      apb(1'b1, `SCLK_ADDR_PLLCFG, pc[k]);
      repeat (3) @(posedge CLK);
      chk({31'h0, PLL_ENABLE}, 32'h1);
      for (i = 0; i < 4000 && PLL_LOCKED !== 1'b1; i++) @(posedge CLK);
      chk({31'h0, PLL_LOCKED}, 32'h1);
      meas(per, hiw);
      sum = 0;
      repeat (4) begin
        meas(per, hiw);
        sum += per;
      end
      chk(near(sum, 4 * pe[k], 2), 4 * pe[k]);
    end
    apb(1'b0, `SCLK_ADDR_STATUS, 32'h0);
    chk(rdat & ~32'h40, 32'h01e00034);
    apb(1'b1, `SCLK_ADDR_SYSCFG, 32'h3);
    meas(per, hiw);
    meas(per, hiw);
    chk(per, 7);
    chk(hiw, 4);
    chk({31'h0, PLL_ENABLE}, 32'h0);
    chk_rd(`SCLK_ADDR_STATUS, 32'h01e00008, 1'b0);
    apb(1'b1, `SCLK_ADDR_SYSCFG, 32'h0);
    repeat (3) @(posedge CLK);
    meas(per, hiw);
    chk(per, 5);
    chk(hiw, 3);
    close_out;
  end
endmodule

`default_nettype wire

// ---- verilog/sclk_div.sv ----
// Purpose: divides a sampled clock level by a factor, passing it through at factor one
// Assumes: src_lvl sampled on clk; factor never zero
// Notes:   a new factor is taken only at a period boundary
`timescale 1ns/1ps
`default_nettype none

module sclk_div
  import sclk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // divider
  input wire logic src_lvl,
  input wire logic [10:0] factor,
  output logic div_out
);

  sclk_div_s st_r;
  sclk_div_s st_nxt;
  logic rise;
  logic fall;

  assign rise = src_lvl & ~st_r.src_d;
  assign fall = ~src_lvl & st_r.src_d;
  assign div_out = st_r.out;

  always_comb begin
    st_nxt = st_r;
    st_nxt.src_d = src_lvl;
    if (st_r.fac == 11'h001) begin
      // pass-through keeps the source duty cycle
      st_nxt.out = src_lvl;
      if (fall && factor != 11'h001) begin
        st_nxt.fac = factor;
        st_nxt.cnt = factor - 11'h001;
      end
    end else if (rise) begin
      if (st_r.cnt == st_r.fac - 11'h001) begin
        st_nxt.fac = factor;
        st_nxt.cnt = 11'h000;
        st_nxt.out = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 11'h001;
        st_nxt.out = (st_r.cnt + 11'h001) < (st_r.fac >> 1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{src_d: 1'b0, cnt: 11'h000, fac: 11'h001, out: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_div_pass: assert property (st_r.fac == 11'h001 |=> div_out == $past(src_lvl))
    else $error("pass-through output does not follow source");
  a_div_wrap: assert property (rise && st_r.fac != 11'h001 && st_r.cnt == st_r.fac - 11'h001 |=> div_out)
    else $error("divided clock not high at period start");
  a_div_hold: assert property (st_r.fac != 11'h001 && !rise |=> $stable(div_out) && $stable(st_r.fac))
    else $error("divided clock changed between source edges");

endmodule

`default_nettype wire

// ---- verilog/sclk_top.sv ----
// Purpose: selects and derives the system clock from wakeup, oscillator, pll or direct input
// Assumes: all clock sources are levels sampled on CLK; APB slave with zero wait states
// Notes:   the pll is a numeric model: an accumulator stands in for the vco
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "sclk_regs.svh"

//
// Overview of operation
// - source select 11 passes the external input clock straight through as system clock
// - source select 10 with bypass divides oscillator or internal clock by prescaler one
// - prescaler one factor is field plus one, at most 1024
// - factor one gives oscillator frequency with the source duty cycle
// - source select 10 without bypass enables the pll and uses its output
// - pll ratio is feedback factor over input divider times output divider
// - pll reference is the crystal input or the internal clock source
// - pll ratio moves gradually toward lock, one step per input-divided reference period
// - system clock is the vco output divided by the output divider factor
// - band select 00 low, 01 middle, 10 high vco band
// - bypass from crystal with factor one is a plain pass-through
// - the low-jitter fieldbus pll runs its vco at 480 MHz
// - source select 00 runs the system clock from the wakeup clock
module sclk_top
  import sclk_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // clock sources
  input wire logic WAKEUP_CLK,
  input wire logic CRYSTAL_IN,
  input wire logic INT_OSC,
  input wire logic EXT_CLOCK_INPUT_ONE,
  // derived clock and status
  output logic SYS_CLK,
  output logic PLL_ENABLE,
  output logic PLL_LOCKED,
  output logic [1:0] VCO_BAND,
  output logic FLASH_SAFE
);

  // -------------------------------------------------------------------------
  // state and helpers
  // -------------------------------------------------------------------------
  sclk_state_s st_r;
  sclk_state_s st_nxt;
  sclk_src_e req_src;
  logic osc_lvl;
  logic k1_lvl;
  logic k2_lvl;
  logic act_lvl;
  logic req_lvl;
  logic ref_rise;
  logic pfd_tick;
  logic pll_on;
  logic [8:0] n_target;
  logic [17:0] acc_sum;
  logic [10:0] k1_factor;
  logic [10:0] k2_factor;
  logic addr_ok;

  function automatic logic pick(input sclk_src_e s, input logic w, input logic p, input logic l, input logic d);
    case (s)
      SRC_WAKE: pick = w;
      SRC_PRESC: pick = p;
      SRC_PLL: pick = l;
      SRC_DIRECT: pick = d;
      default: pick = 1'b0;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // dividers
  // -------------------------------------------------------------------------
  assign k1_factor = {1'b0, st_r.cfg.k1_field} + 11'h001;
  assign k2_factor = {4'h0, st_r.cfg.k2_field} + 11'h001;

  sclk_div u_presc (
    .clk(CLK),
    .rst(RST),
    .src_lvl(osc_lvl),
    .factor(k1_factor),
    .div_out(k1_lvl)
  );

  sclk_div u_outdiv (
    .clk(CLK),
    .rst(RST),
    .src_lvl(st_r.pll.vco),
    .factor(k2_factor),
    .div_out(k2_lvl)
  );

  // -------------------------------------------------------------------------
  // source decode
  // -------------------------------------------------------------------------
  assign osc_lvl = st_r.cfg.ref_sel ? INT_OSC : CRYSTAL_IN;
  assign pll_on = (st_r.cfg.src_sel == `SCLK_SEL_OSC) && !st_r.cfg.bypass;
  assign n_target = {1'b0, st_r.cfg.n_field} + 9'h001;
  assign ref_rise = osc_lvl & ~st_r.pll.ref_d;
  assign pfd_tick = ref_rise && (st_r.pll.input_divider_field_cnt >= st_r.cfg.p_field);
  assign acc_sum = {1'b0, st_r.pll.acc} + {8'h00, st_r.pll.n_eff, 1'b0};
  assign addr_ok = (PADDR == `SCLK_ADDR_SYSCFG) || (PADDR == `SCLK_ADDR_PLLCFG) ||
                   (PADDR == `SCLK_ADDR_PRESC) || (PADDR == `SCLK_ADDR_STMEM) || (PADDR == `SCLK_ADDR_STATUS);

  always_comb begin
    case (st_r.cfg.src_sel)
      `SCLK_SEL_DIRECT: req_src = SRC_DIRECT;
      `SCLK_SEL_OSC: req_src = st_r.cfg.bypass ? SRC_PRESC : SRC_PLL;
      default: req_src = SRC_WAKE;
    endcase
  end

  assign act_lvl = pick(st_r.act, WAKEUP_CLK, k1_lvl, k2_lvl, EXT_CLOCK_INPUT_ONE);
  assign req_lvl = pick(req_src, WAKEUP_CLK, k1_lvl, k2_lvl, EXT_CLOCK_INPUT_ONE);

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pready = 1'b1;
    // apb setup: decode and prepare read data
    if (PSEL && !PENABLE) begin
      st_nxt.pslverr = !addr_ok;
      st_nxt.prdata = 32'h0000_0000;
      case (PADDR)
        `SCLK_ADDR_SYSCFG: st_nxt.prdata[`SCLK_SYS_SRC_LSB +: 2] = st_r.cfg.src_sel;
        `SCLK_ADDR_PLLCFG: begin
          st_nxt.prdata[`SCLK_PLL_BYP_BIT] = st_r.cfg.bypass;
          st_nxt.prdata[`SCLK_PLL_BAND_LSB +: 2] = st_r.cfg.band;
          st_nxt.prdata[`SCLK_PLL_REF_BIT] = st_r.cfg.ref_sel;
          st_nxt.prdata[`SCLK_PLL_P_LSB +: 4] = st_r.cfg.p_field;
          st_nxt.prdata[`SCLK_PLL_N_LSB +: 8] = st_r.cfg.n_field;
          st_nxt.prdata[`SCLK_PLL_K2_LSB +: 7] = st_r.cfg.k2_field;
        end
        `SCLK_ADDR_PRESC: st_nxt.prdata[`SCLK_PRESC_K1_LSB +: 10] = st_r.cfg.k1_field;
        `SCLK_ADDR_STMEM: st_nxt.prdata[`SCLK_STMEM_SAFE_BIT] = st_r.cfg.flash_safe;
        `SCLK_ADDR_STATUS: begin
          st_nxt.prdata[`SCLK_STAT_SRC_LSB +: 4] = st_r.act;
          st_nxt.prdata[`SCLK_STAT_LOCK_BIT] = st_r.pll.locked;
          st_nxt.prdata[`SCLK_STAT_PLLEN_BIT] = st_r.pll.enable;
          st_nxt.prdata[`SCLK_STAT_SWBUSY_BIT] = (st_r.sw == SW_WAIT);
          st_nxt.prdata[`SCLK_STAT_LJ_LSB +: 9] = `SCLK_LJ_VCO_MHZ;
        end
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // apb access: writes take effect at the completing edge
    if (PSEL && PENABLE && PWRITE && !st_r.pslverr) begin
      case (PADDR)
        `SCLK_ADDR_SYSCFG: st_nxt.cfg.src_sel = PWDATA[`SCLK_SYS_SRC_LSB +: 2];
        `SCLK_ADDR_PLLCFG: begin
          st_nxt.cfg.bypass = PWDATA[`SCLK_PLL_BYP_BIT];
          st_nxt.cfg.band = PWDATA[`SCLK_PLL_BAND_LSB +: 2];
          st_nxt.cfg.ref_sel = PWDATA[`SCLK_PLL_REF_BIT];
          st_nxt.cfg.p_field = PWDATA[`SCLK_PLL_P_LSB +: 4];
          st_nxt.cfg.n_field = PWDATA[`SCLK_PLL_N_LSB +: 8];
          st_nxt.cfg.k2_field = PWDATA[`SCLK_PLL_K2_LSB +: 7];
        end
        `SCLK_ADDR_PRESC: st_nxt.cfg.k1_field = PWDATA[`SCLK_PRESC_K1_LSB +: 10];
        `SCLK_ADDR_STMEM: st_nxt.cfg.flash_safe = PWDATA[`SCLK_STMEM_SAFE_BIT];
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end

    // pll model: input divider, reference period, slewing vco accumulator
    st_nxt.pll.ref_d = osc_lvl;
    st_nxt.pll.enable = pll_on;
    if (!pll_on) begin
      st_nxt.pll.input_divider_field_cnt = 4'h0;
      st_nxt.pll.per_cnt = 16'h0000;
      st_nxt.pll.pfd_per = 16'h0000;
      st_nxt.pll.n_eff = 9'h001;
      st_nxt.pll.acc = 17'h00000;
      st_nxt.pll.vco = 1'b0;
      st_nxt.pll.locked = 1'b0;
    end else begin
      if (st_r.pll.per_cnt != 16'hffff) begin
        st_nxt.pll.per_cnt = st_r.pll.per_cnt + 16'h0001;
      end
      if (ref_rise) begin
        st_nxt.pll.input_divider_field_cnt = pfd_tick ? 4'h0 : st_r.pll.input_divider_field_cnt + 4'h1;
      end
      if (pfd_tick) begin
        st_nxt.pll.pfd_per = st_r.pll.per_cnt;
        st_nxt.pll.per_cnt = 16'h0001;
        // one step per input-divided reference period (each pfd_tick) toward the target ratio
        if (st_r.pll.n_eff < n_target) begin
          st_nxt.pll.n_eff = st_r.pll.n_eff + 9'h001;
        end else if (st_r.pll.n_eff > n_target) begin
          st_nxt.pll.n_eff = st_r.pll.n_eff - 9'h001;
        end
      end
      if (st_r.pll.pfd_per != 16'h0000) begin
        if (acc_sum >= {2'b00, st_r.pll.pfd_per}) begin
          st_nxt.pll.vco = ~st_r.pll.vco;
          // clamp when the vco would outrun the sampling clock
          st_nxt.pll.acc = (acc_sum - {2'b00, st_r.pll.pfd_per} >= {2'b00, st_r.pll.pfd_per}) ?
                           17'h00000 : 17'(acc_sum - {2'b00, st_r.pll.pfd_per});
        end else begin
          st_nxt.pll.acc = acc_sum[16:0];
        end
      end
      st_nxt.pll.locked = (st_r.pll.n_eff == n_target) && (st_r.pll.pfd_per != 16'h0000);
    end

    // glitch-free source switch: finish the high phase, then change while both are low
    case (st_r.sw)
      SW_RUN: begin
        st_nxt.sys_clk = act_lvl;
        if (req_src != st_r.act) begin
          st_nxt.sw = SW_WAIT;
        end
      end
      SW_WAIT: begin
        st_nxt.sys_clk = st_r.sys_clk ? act_lvl : 1'b0;
        if (!st_r.sys_clk && !req_lvl) begin
          st_nxt.act = req_src;
          st_nxt.sw = SW_RUN;
        end
      end
      default: begin
        st_nxt.sw = SW_RUN;
        st_nxt.sys_clk = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r.prdata <= 32'h0000_0000;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.cfg <= '{src_sel: `SCLK_RST_SRC, bypass: `SCLK_RST_BYP, band: `SCLK_RST_BAND,
                    ref_sel: `SCLK_RST_REF, p_field: `SCLK_RST_P, n_field: `SCLK_RST_N,
                    k2_field: `SCLK_RST_K2, k1_field: `SCLK_RST_K1, flash_safe: `SCLK_RST_SAFE};
      st_r.pll <= '{ref_d: 1'b0, input_divider_field_cnt: 4'h0, per_cnt: 16'h0000, pfd_per: 16'h0000, n_eff: 9'h001,
                    acc: 17'h00000, vco: 1'b0, locked: 1'b0, enable: 1'b0};
      st_r.sw <= SW_RUN;
      st_r.act <= SRC_WAKE;
      st_r.sys_clk <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign SYS_CLK = st_r.sys_clk;
  assign PLL_ENABLE = st_r.pll.enable;
  assign PLL_LOCKED = st_r.pll.locked;
  assign VCO_BAND = st_r.cfg.band;
  assign FLASH_SAFE = st_r.cfg.flash_safe;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_status_setup;
    PSEL && !PENABLE && PADDR == `SCLK_ADDR_STATUS;
  endsequence

  sequence s_status_access;
    PSEL && PENABLE && PREADY;
  endsequence

  a_direct_follow: assert property (st_r.sw == SW_RUN && st_r.act == SRC_DIRECT |=> SYS_CLK == $past(EXT_CLOCK_INPUT_ONE))
    else $error("direct drive does not follow external input");
  a_wake_follow: assert property (st_r.sw == SW_RUN && st_r.act == SRC_WAKE |=> SYS_CLK == $past(WAKEUP_CLK))
    else $error("wakeup mode does not follow wakeup clock");
  a_presc_follow: assert property (st_r.sw == SW_RUN && st_r.act == SRC_PRESC |=> SYS_CLK == $past(k1_lvl))
    else $error("prescaler mode does not use prescaler output");
  a_pll_enable: assert property (st_r.cfg.src_sel == `SCLK_SEL_OSC && !st_r.cfg.bypass |=> PLL_ENABLE)
    else $error("pll not enabled in pll mode");
  a_pll_slew: assert property (pll_on && st_r.pll.enable |=> (st_r.pll.n_eff - $past(st_r.pll.n_eff) <= 9'h001) ||
                                                ($past(st_r.pll.n_eff) - st_r.pll.n_eff <= 9'h001))
    else $error("pll ratio moved by more than one step");
  a_pll_lock: assert property (PLL_LOCKED && pll_on |-> st_r.pll.n_eff == n_target)
    else $error("pll reports lock away from target ratio");
  a_switch_low: assert property (st_r.sw == SW_WAIT && !SYS_CLK |=> !SYS_CLK)
    else $error("system clock pulse during source switch");
  a_lj_status: assert property (s_status_setup ##1 s_status_access |-> PRDATA[`SCLK_STAT_LJ_LSB +: 9] == 9'h1e0)
    else $error("low-jitter vco frequency misreported");
  a_band_out: assert property (PSEL && PENABLE && PWRITE && PADDR == `SCLK_ADDR_PLLCFG && !PSLVERR
                               |=> VCO_BAND == $past(PWDATA[`SCLK_PLL_BAND_LSB +: 2]))
    else $error("band select not applied");

  // -------------------------------------------------------------------------
  // pll, prescaler and switch checks
  // -------------------------------------------------------------------------
  sequence s_switch_ready;
    st_r.sw == SW_WAIT && !st_r.sys_clk && !req_lvl;
  endsequence

  a_pll_divout: assert property (st_r.sw == SW_RUN && st_r.act == SRC_PLL |=> SYS_CLK == $past(k2_lvl))
    else $error("pll mode does not use output divider");
  a_pll_off: assert property (!pll_on |=> !PLL_ENABLE && !PLL_LOCKED)
    else $error("pll still enabled outside pll mode");
  a_lock_period: assert property (PLL_LOCKED |-> st_r.pll.pfd_per != 16'h0000)
    else $error("pll lock without measured reference period");
  a_slew_up: assert property (pfd_tick && pll_on && st_r.pll.n_eff < n_target
                              |=> st_r.pll.n_eff == $past(st_r.pll.n_eff) + 9'h001)
    else $error("pll ratio did not step up by one");
  a_slew_down: assert property (pfd_tick && pll_on && st_r.pll.n_eff > n_target
                                |=> st_r.pll.n_eff == $past(st_r.pll.n_eff) - 9'h001)
    else $error("pll ratio did not step down by one");
  a_slew_still: assert property (!pfd_tick && pll_on |=> $stable(st_r.pll.n_eff))
    else $error("pll ratio moved between reference ticks");
  a_ref_pick: assert property (pll_on |=> st_r.pll.ref_d == $past(st_r.cfg.ref_sel ? INT_OSC : CRYSTAL_IN))
    else $error("pll reference taken from wrong source");
  a_k1_range: assert property (k1_factor != 11'h000 && k1_factor <= 11'h400)
    else $error("prescaler factor out of range");
  a_band_hold: assert property (!(PSEL && PENABLE && PWRITE) |=> $stable(VCO_BAND))
    else $error("band select changed without a write");
  a_switch_start: assert property (st_r.sw == SW_RUN && req_src != st_r.act |=> st_r.sw == SW_WAIT)
    else $error("source change did not start a switch");
  a_switch_finish: assert property (st_r.sw == SW_WAIT && SYS_CLK && !act_lvl |=> !SYS_CLK)
    else $error("high phase not ended with old source");
  a_switch_take: assert property (s_switch_ready |=> st_r.act == $past(req_src) && st_r.sw == SW_RUN)
    else $error("requested source not taken while low");

endmodule

`default_nettype wire
